// ---- common/uaf_regs.vh ----
`ifndef UAF_REGS_VH
`define UAF_REGS_VH

// register byte addresses
`define UAF_DATA_ADDR      32'he001_0000
`define UAF_DIVHI_ADDR     32'he001_0004
`define UAF_FCR_ADDR       32'he001_0008
`define UAF_LCR_ADDR       32'he001_000c
`define UAF_MCR_ADDR       32'he001_0010
`define UAF_STAT_ADDR      32'he001_0014

// fifo_control fields
`define UAF_FCR_EN         0
`define UAF_FCR_RXCLR      1
`define UAF_FCR_TXCLR      2
`define UAF_FCR_TRIG_HI    7
`define UAF_FCR_TRIG_LO    6

// line_format_control fields
`define UAF_LCR_WL_HI      1
`define UAF_LCR_WL_LO      0
`define UAF_LCR_STOP       2
`define UAF_LCR_PEN        3
`define UAF_LCR_PS_HI      5
`define UAF_LCR_PS_LO      4
`define UAF_LCR_BRK        6
`define UAF_LCR_DLAB       7

// modem_output_control fields
`define UAF_MCR_DTR        0
`define UAF_MCR_RTS        1
`define UAF_MCR_LOOP       4

// parity select codes
`define UAF_PS_ODD         2'h0
`define UAF_PS_EVEN        2'h1
`define UAF_PS_ONE         2'h2
`define UAF_PS_ZERO        2'h3

// reset values
`define UAF_LCR_RST        8'h00
`define UAF_MCR_RST        5'h00
`define UAF_TRIG_RST       2'h0
`define UAF_DIV_RST        16'h0001

// oversample timing, last tick index of each span, then the last data bit index for five-bit characters
`define UAF_BIT_LAST       5'h0f
`define UAF_HALF_LAST      5'h07
`define UAF_STOP15_LAST    5'h17
`define UAF_STOP2_LAST     5'h1f
`define UAF_WL_BASE        3'h4

`endif

// ---- core/uaf_sync.v ----
module uaf_sync #(
	parameter RST_VAL = 1'b1
) (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	// async level in, synchronised level out
	input  wire din,
	output wire dout
);

reg stage1_reg;
reg stage2_reg;

// first stage feeds only the second
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stage1_reg <= RST_VAL;
		stage2_reg <= RST_VAL;
	end else begin
		stage1_reg <= din;
		stage2_reg <= stage1_reg;
	end
end

assign dout = stage2_reg;

endmodule

// ---- core/uaf_fifo.v ----
module uaf_fifo #(
	parameter WIDTH = 8,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// control
	input  wire             flush,
	// write side
	input  wire             push,
	input  wire [WIDTH-1:0] wr_data,
	// read side, rd_data shows the head entry
	input  wire             pop,
	output reg  [WIDTH-1:0] rd_data,
	// state
	output wire [AW:0]      count,
	output wire             empty,
	output wire             full
);

localparam DEPTH = 1 << AW;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0]      wr_ptr_reg;
reg [AW:0]      rd_ptr_reg;
reg [AW:0]      wr_ptr_next;
reg [AW:0]      rd_ptr_next;

assign count = wr_ptr_reg - rd_ptr_reg;
assign empty = (count == {(AW+1){1'b0}});
assign full  = count[AW];

always @* begin
	wr_ptr_next = wr_ptr_reg;
	rd_ptr_next = rd_ptr_reg;
	if (flush) begin
		wr_ptr_next = {(AW+1){1'b0}};
		rd_ptr_next = {(AW+1){1'b0}};
	end else begin
		if (push && !full)
			wr_ptr_next = wr_ptr_reg + 1'b1;
		if (pop && !empty)
			rd_ptr_next = rd_ptr_reg + 1'b1;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wr_ptr_reg <= {(AW+1){1'b0}};
		rd_ptr_reg <= {(AW+1){1'b0}};
	end else begin
		wr_ptr_reg <= wr_ptr_next;
		rd_ptr_reg <= rd_ptr_next;
	end
end

// read data looks ahead at the next head so a pop never leaves it stale
always @(posedge pclk) begin
	if (push && !full && !flush)
		mem[wr_ptr_reg[AW-1:0]] <= wr_data;
	if (push && !full && !flush && rd_ptr_next == wr_ptr_reg)
		rd_data <= wr_data;
	else
		rd_data <= mem[rd_ptr_next[AW-1:0]];
end

endmodule

// ---- core/uaf_uart_ctrl.v ----
// Behaviour
// RL1 - fifo enable bit turns on both fifos and lets bits 7:1 take effect
// RL2 - any change of the fifo enable bit empties both fifos
// RL3 - writing one to bit 1 empties the receive fifo; bit self-clears
// RL4 - writing one to bit 2 empties the transmit fifo; bit self-clears
// RL5 - software writes zero to reserved bits 5:3; reads of them are undefined
// RL6 - bits 7:6 pick receive trigger level 1, 4, 8 or 14
// RL7 - the four trigger levels are build-time parameters
// RL8 - line bits 1:0 pick five to eight data bits
// RL9 - bit 2 picks two stop bits, one and a half for five-bit characters
// RL10 - bit 3 turns parity generation and checking on
// RL11 - bits 5:4 pick odd, even, stuck one or stuck zero parity
// RL12 - bit 6 holds the transmit pin low for a break
// RL13 - bit 7 opens access to the divisor latches
// RL14 - modem bit 0 drives data terminal ready; reads zero in loopback
// RL15 - modem bit 1 drives request to send; reads zero in loopback
// RL16 - loopback feeds transmitter to receiver, pin marks, receive pin ignored
// RL17 - data available irq follows fifo occupancy against the trigger level
// RL18 - fifo control writes with enable clear leave bits 7:1 unchanged
// RL19 - all configuration fields reset to zero; here the divisor latches reset to one
//
// Design decision made here: the APB register port.
`include "uaf_regs.vh"

module uaf_uart_ctrl #(
	parameter       AW    = 4,
	parameter [4:0] TRIG0 = 5'h01,
	parameter [4:0] TRIG1 = 5'h04,
	parameter [4:0] TRIG2 = 5'h08,
	parameter [4:0] TRIG3 = 5'h0e
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// serial line
	input  wire        rxd,
	output reg         txd,
	output reg         dtr_n,
	output reg         rts_n,
	// interrupt level
	output reg         rx_data_available_irq
);

localparam ST_IDLE  = 3'h0;
localparam ST_START = 3'h1;
localparam ST_DATA  = 3'h2;
localparam ST_PAR   = 3'h3;
localparam ST_STOP  = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// helpers

function [7:0] wl_mask;
	input [1:0] wl;
	begin
		wl_mask = 8'hff >> (2'h3 - wl);
	end
endfunction

function par_bit;
	input [7:0] data;
	input [1:0] wl;
	input [1:0] ps;
	begin
		case (ps)
			`UAF_PS_ODD:  par_bit = ~^(data & wl_mask(wl));
			`UAF_PS_EVEN: par_bit = ^(data & wl_mask(wl));
			`UAF_PS_ONE:  par_bit = 1'b1;
			default:      par_bit = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers and wires

reg        fcr_en_reg;
reg [1:0]  trig_sel_reg;
reg [7:0]  lcr_reg;
reg [4:0]  mcr_reg;
reg [7:0]  dll_reg;
reg [7:0]  dlm_reg;
reg        pe_flag_reg;
reg        fe_flag_reg;
reg        oe_flag_reg;
reg [15:0] div_cnt_reg;
reg        tick_reg;
reg [2:0]  tx_state_reg;
reg [4:0]  tx_cnt_reg;
reg [2:0]  tx_bit_reg;
reg [7:0]  tx_shift_reg;
reg        tx_ser_reg;
reg [2:0]  rx_state_reg;
reg [4:0]  rx_cnt_reg;
reg [2:0]  rx_bit_reg;
reg [7:0]  rx_shift_reg;
reg        rx_perr_reg;
reg        rx_push;
reg        rx_fe;
reg        tx_pop;
reg [4:0]  trig_lvl;
reg [31:0] rd_mux;

wire        dlab     = lcr_reg[`UAF_LCR_DLAB];
wire        loop     = mcr_reg[`UAF_MCR_LOOP];
wire [1:0]  wl       = lcr_reg[`UAF_LCR_WL_HI:`UAF_LCR_WL_LO];
wire [1:0]  ps       = lcr_reg[`UAF_LCR_PS_HI:`UAF_LCR_PS_LO];
wire        pen      = lcr_reg[`UAF_LCR_PEN];
wire [2:0]  last_bit = `UAF_WL_BASE + {1'b0, wl};
wire        wr       = psel & penable & pwrite;
wire        rd_setup = psel & ~penable & ~pwrite;
wire        rd_acc   = psel & penable & ~pwrite;
wire        a_data   = (paddr == `UAF_DATA_ADDR);
wire        a_divhi  = (paddr == `UAF_DIVHI_ADDR);
wire        a_fcr    = (paddr == `UAF_FCR_ADDR);
wire        a_lcr    = (paddr == `UAF_LCR_ADDR);
wire        a_mcr    = (paddr == `UAF_MCR_ADDR);
wire        a_stat   = (paddr == `UAF_STAT_ADDR);
wire        hit      = a_data | a_divhi | a_fcr | a_lcr | a_mcr | a_stat;
wire        fcr_wr   = wr & a_fcr;
wire        new_en   = pwdata[`UAF_FCR_EN];
// RL2 enable toggle flushes both
wire        en_flip  = fcr_wr & (new_en != fcr_en_reg);
// RL3 RL4 clear bits need enable written, so a disabled write flushes only by changing the enable
wire        rx_flush = en_flip | (fcr_wr & new_en & pwdata[`UAF_FCR_RXCLR]);
wire        tx_flush = en_flip | (fcr_wr & new_en & pwdata[`UAF_FCR_TXCLR]);
wire        stat_rd  = rd_acc & a_stat;
wire        rx_pop   = rd_acc & a_data & ~dlab;
wire        tx_push;
wire [7:0]  rx_rd_data;
wire [7:0]  tx_rd_data;
wire [AW:0] rx_count;
wire [AW:0] tx_count;
wire        rx_empty;
wire        rx_full;
wire        tx_empty;
wire        tx_full;
wire        rxd_s;
wire        rx_in;
// with fifos disabled each direction holds a single character
wire        rx_full_eff = fcr_en_reg ? rx_full : ~rx_empty;
wire        tx_full_eff = fcr_en_reg ? tx_full : ~tx_empty;

assign pready  = 1'b1;
assign pslverr = psel & penable & ~hit;
assign tx_push = wr & a_data & ~dlab & ~tx_full_eff;
// loopback takes the transmitter instead of the pin
assign rx_in   = loop ? tx_ser_reg : rxd_s;

////////////////////////////////////////////////////////////////////////////////
// submodules

uaf_sync #(
	.RST_VAL (1'b1)
) u_rxd_sync (
	.pclk    (pclk),
	.presetn (presetn),
	.din     (rxd),
	.dout    (rxd_s)
);

uaf_fifo #(
	.WIDTH (8),
	.AW    (AW)
) u_rx_fifo (
	.pclk    (pclk),
	.presetn (presetn),
	.flush   (rx_flush),
	.push    (rx_push & ~rx_full_eff),
	.wr_data (rx_shift_reg),
	.pop     (rx_pop),
	.rd_data (rx_rd_data),
	.count   (rx_count),
	.empty   (rx_empty),
	.full    (rx_full)
);

uaf_fifo #(
	.WIDTH (8),
	.AW    (AW)
) u_tx_fifo (
	.pclk    (pclk),
	.presetn (presetn),
	.flush   (tx_flush),
	.push    (tx_push),
	.wr_data (pwdata[7:0]),
	.pop     (tx_pop),
	.rd_data (tx_rd_data),
	.count   (tx_count),
	.empty   (tx_empty),
	.full    (tx_full)
);

////////////////////////////////////////////////////////////////////////////////
// configuration registers

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		// RL19 all fields zero except the divisor, which loads one
		fcr_en_reg   <= 1'b0;
		trig_sel_reg <= `UAF_TRIG_RST;
		lcr_reg      <= `UAF_LCR_RST;
		mcr_reg      <= `UAF_MCR_RST;
		{dlm_reg, dll_reg} <= `UAF_DIV_RST;
	end else if (wr) begin
		// RL1 enable and gate
		if (a_fcr)
			fcr_en_reg <= new_en;
		// RL18 ignore when disabled
		if (a_fcr && new_en)
			trig_sel_reg <= pwdata[`UAF_FCR_TRIG_HI:`UAF_FCR_TRIG_LO];
		if (a_lcr)
			lcr_reg <= pwdata[7:0];
		if (a_mcr)
			mcr_reg <= {pwdata[`UAF_MCR_LOOP], 2'h0, pwdata[`UAF_MCR_RTS], pwdata[`UAF_MCR_DTR]};
		// RL13 divisor gated
		if (a_data && dlab)
			dll_reg <= pwdata[7:0];
		if (a_divhi && dlab)
			dlm_reg <= pwdata[7:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// register read and sticky error flags

always @* begin
	trig_lvl = TRIG0;
	// RL6 trigger select
	case (trig_sel_reg)
		2'h0:    trig_lvl = TRIG0;
		2'h1:    trig_lvl = TRIG1;
		2'h2:    trig_lvl = TRIG2;
		default: trig_lvl = TRIG3;
	endcase
	rd_mux = 32'h0000_0000;
	if (a_data)
		rd_mux = dlab ? {24'h00_0000, dll_reg} : {24'h00_0000, rx_rd_data};
	else if (a_divhi)
		rd_mux = dlab ? {24'h00_0000, dlm_reg} : 32'h0000_0000;
	// RL5 reserved read zero
	else if (a_fcr)
		rd_mux = {24'h00_0000, trig_sel_reg, 5'h00, fcr_en_reg};
	else if (a_lcr)
		rd_mux = {24'h00_0000, lcr_reg};
	// RL14 RL15 read zero in loopback
	else if (a_mcr)
		rd_mux = {27'h000_0000, mcr_reg[4], 2'h0, mcr_reg[1] & ~loop, mcr_reg[0] & ~loop};
	else if (a_stat)
		rd_mux = {16'h0000, {(7 - AW){1'b0}}, tx_count, 2'h0,
			rx_data_available_irq, tx_empty, oe_flag_reg, fe_flag_reg, pe_flag_reg, ~rx_empty};
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata      <= 32'h0000_0000;
		pe_flag_reg <= 1'b0;
		fe_flag_reg <= 1'b0;
		oe_flag_reg <= 1'b0;
	end else begin
		if (rd_setup)
			prdata <= rd_mux;
		// set wins over the read clear
		pe_flag_reg <= (rx_push & rx_perr_reg) | (pe_flag_reg & ~stat_rd);
		fe_flag_reg <= (rx_push & rx_fe) | (fe_flag_reg & ~stat_rd);
		oe_flag_reg <= (rx_push & rx_full_eff) | (oe_flag_reg & ~stat_rd);
	end
end

////////////////////////////////////////////////////////////////////////////////
// baud tick, sixteen per bit

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_cnt_reg <= 16'h0000;
		tick_reg    <= 1'b0;
	end else if (div_cnt_reg == 16'h0000) begin
		// zero divisor behaves as one
		div_cnt_reg <= ({dlm_reg, dll_reg} == 16'h0000) ? 16'h0000 : {dlm_reg, dll_reg} - 16'h0001;
		tick_reg    <= 1'b1;
	end else begin
		div_cnt_reg <= div_cnt_reg - 16'h0001;
		tick_reg    <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter

always @* begin
	tx_pop = tick_reg & (tx_state_reg == ST_IDLE) & ~tx_empty & ~tx_flush;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		tx_state_reg <= ST_IDLE;
		tx_cnt_reg   <= 5'h00;
		tx_bit_reg   <= 3'h0;
		tx_shift_reg <= 8'h00;
		tx_ser_reg   <= 1'b1;
	end else if (tick_reg) begin
		tx_cnt_reg <= tx_cnt_reg + 5'h01;
		case (tx_state_reg)
			ST_IDLE: begin
				tx_cnt_reg <= 5'h00;
				tx_ser_reg <= 1'b1;
				if (tx_pop) begin
					tx_shift_reg <= tx_rd_data;
					tx_ser_reg   <= 1'b0;
					tx_state_reg <= ST_START;
				end
			end
			ST_START: begin
				if (tx_cnt_reg == `UAF_BIT_LAST) begin
					tx_cnt_reg   <= 5'h00;
					tx_bit_reg   <= 3'h0;
					tx_ser_reg   <= tx_shift_reg[0];
					tx_state_reg <= ST_DATA;
				end
			end
			ST_DATA: begin
				if (tx_cnt_reg == `UAF_BIT_LAST) begin
					tx_cnt_reg <= 5'h00;
					tx_bit_reg <= tx_bit_reg + 3'h1;
					tx_ser_reg <= tx_shift_reg[tx_bit_reg + 3'h1];
					// RL8 character width
					if (tx_bit_reg == last_bit) begin
						// RL10 RL11 parity out
						tx_ser_reg   <= pen ? par_bit(tx_shift_reg, wl, ps) : 1'b1;
						tx_state_reg <= pen ? ST_PAR : ST_STOP;
					end
				end
			end
			ST_PAR: begin
				if (tx_cnt_reg == `UAF_BIT_LAST) begin
					tx_cnt_reg   <= 5'h00;
					tx_ser_reg   <= 1'b1;
					tx_state_reg <= ST_STOP;
				end
			end
			ST_STOP: begin
				// RL9 stop length
				if ((!lcr_reg[`UAF_LCR_STOP] && tx_cnt_reg == `UAF_BIT_LAST) ||
				    (lcr_reg[`UAF_LCR_STOP] && wl == 2'h0 && tx_cnt_reg == `UAF_STOP15_LAST) ||
				    (lcr_reg[`UAF_LCR_STOP] && wl != 2'h0 && tx_cnt_reg == `UAF_STOP2_LAST)) begin
					tx_cnt_reg   <= 5'h00;
					tx_state_reg <= ST_IDLE;
				end
			end
			default: tx_state_reg <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// receiver

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rx_state_reg <= ST_IDLE;
		rx_cnt_reg   <= 5'h00;
		rx_bit_reg   <= 3'h0;
		rx_shift_reg <= 8'h00;
		rx_perr_reg  <= 1'b0;
		rx_push      <= 1'b0;
		rx_fe        <= 1'b0;
	end else begin
		rx_push <= 1'b0;
		if (tick_reg) begin
			rx_cnt_reg <= rx_cnt_reg + 5'h01;
			case (rx_state_reg)
				ST_IDLE: begin
					rx_cnt_reg <= 5'h00;
					if (!rx_in) begin
						rx_shift_reg <= 8'h00;
						rx_state_reg <= ST_START;
					end
				end
				ST_START: begin
					// mid start bit; a glitch returns to idle
					if (rx_cnt_reg == `UAF_HALF_LAST) begin
						rx_cnt_reg   <= 5'h00;
						rx_bit_reg   <= 3'h0;
						rx_state_reg <= rx_in ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_cnt_reg == `UAF_BIT_LAST) begin
						rx_cnt_reg               <= 5'h00;
						rx_shift_reg[rx_bit_reg] <= rx_in;
						rx_bit_reg               <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == last_bit)
							rx_state_reg <= pen ? ST_PAR : ST_STOP;
					end
				end
				ST_PAR: begin
					// RL10 RL11 parity check
					if (rx_cnt_reg == `UAF_BIT_LAST) begin
						rx_cnt_reg   <= 5'h00;
						rx_perr_reg  <= (rx_in != par_bit(rx_shift_reg, wl, ps));
						rx_state_reg <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_cnt_reg == `UAF_BIT_LAST) begin
						rx_cnt_reg   <= 5'h00;
						rx_fe        <= ~rx_in;
						rx_push      <= 1'b1;
						rx_state_reg <= ST_IDLE;
					end
				end
				default: rx_state_reg <= ST_IDLE;
			endcase
		end
		if (rx_push)
			rx_perr_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pins and interrupt

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		txd                   <= 1'b1;
		dtr_n                 <= 1'b1;
		rts_n                 <= 1'b1;
		rx_data_available_irq <= 1'b0;
	end else begin
		// RL16 RL12 loopback marks, else break forces low
		txd <= loop ? 1'b1 : (tx_ser_reg & ~lcr_reg[`UAF_LCR_BRK]);
		// RL14 RL15 modem outputs, inactive in loopback
		dtr_n <= ~(mcr_reg[`UAF_MCR_DTR] & ~loop);
		rts_n <= ~(mcr_reg[`UAF_MCR_RTS] & ~loop);
		// RL17 RL7 occupancy against trigger
		rx_data_available_irq <= fcr_en_reg ? ({{(5 - AW){1'b0}}, rx_count} >= {1'b0, trig_lvl}) : ~rx_empty;
	end
end

endmodule

// ---- sim/uaf_uart_ctrl_asserts.sv ----
`include "uaf_regs.vh"

module uaf_uart_ctrl_asserts (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// line
	input wire        rxd,
	input wire        txd,
	input wire        dtr_n,
	input wire        rts_n,
	input wire        rx_data_available_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] lcr_q;
	logic [1:0] mcr_q;
	logic [1:0] trig_q;
	logic       fen_q;
	logic       loop_q;
	logic       loop_d;
	logic       brk_d;
	wire        acc = psel && penable;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// shadow of what software wrote, updated at the same edge as the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcr_q <= 8'h00;
			mcr_q <= 2'h0;
			trig_q <= 2'h0;
			fen_q <= 1'b0;
			loop_q <= 1'b0;
			loop_d <= 1'b0;
			brk_d <= 1'b0;
		end else begin
			loop_d <= loop_q;
			brk_d <= lcr_q[6];
			if (acc && pwrite && paddr == `UAF_LCR_ADDR)
				lcr_q <= pwdata[7:0];
			if (acc && pwrite && paddr == `UAF_MCR_ADDR) begin
				mcr_q <= pwdata[1:0];
				loop_q <= pwdata[4];
			end
			// trigger kept when enable written clear
			if (acc && pwrite && paddr == `UAF_FCR_ADDR) begin
				fen_q <= pwdata[0];
				if (pwdata[0])
					trig_q <= pwdata[7:6];
			end
		end
	end

	sequence s_mcr_wr;
		acc && pwrite && paddr == `UAF_MCR_ADDR;
	endsequence
	sequence s_rd(logic [31:0] a);
		acc && !pwrite && paddr == a;
	endsequence

	a_dtr_follow:
	assert property ((s_mcr_wr ##2 1'b1) |-> dtr_n == !(mcr_q[0] && !loop_q)) else $error("dtr_n wrong after write");
	a_rts_follow:
	assert property ((s_mcr_wr ##2 1'b1) |-> rts_n == !(mcr_q[1] && !loop_q)) else $error("rts_n wrong after write");
	a_break_low:
	assert property (lcr_q[6] && brk_d && !loop_q && !loop_d |-> !txd) else $error("txd not low in break");
	a_loop_mark:
	assert property (loop_q && loop_d |-> txd) else $error("txd not marking in loopback");
	a_mcr_read:
	assert property (s_rd(`UAF_MCR_ADDR) |-> prdata[7:0] == {3'h0, loop_q, 2'h0, mcr_q & ~{2{loop_q}}})
		else $error("modem control read wrong");
	a_fcr_read:
	assert property (s_rd(`UAF_FCR_ADDR) |-> prdata[7:0] == {trig_q, 5'h00, fen_q}) else $error("fifo control read wrong");
	a_lcr_read:
	assert property (s_rd(`UAF_LCR_ADDR) |-> prdata[7:0] == lcr_q) else $error("line control read wrong");
	a_reset_idle:
	assert property ($rose(presetn) |-> !rx_data_available_irq && txd && dtr_n && rts_n)
		else $error("outputs not idle after reset");
endmodule

bind uaf_uart_ctrl uaf_uart_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxd(rxd), .txd(txd), .dtr_n(dtr_n), .rts_n(rts_n), .rx_data_available_irq(rx_data_available_irq));

// ---- sim/uaf_line_partner.sv ----
module uaf_line_partner #(
	parameter int BIT = 16
) (
	// clock
	input wire pclk,
	// line toward the block, idles at marking
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial rxd = 1'b1;

	// frame bits go out lsb first, then the line returns to marking
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
endmodule

// ---- sim/uaf_uart_ctrl_test.sv ----
`include "uaf_regs.vh"

module uaf_uart_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, dtr_n, rts_n, irq, err;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [7:0]  lv [6] = '{8'h04, 8'h09, 8'h1e, 8'h2b, 8'h3f, 8'h03};
	logic [3:0]  good = 4'b0110;
	int          miscompares = 0;
	int          checks = 0;

	uaf_uart_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.txd(txd), .dtr_n(dtr_n), .rts_n(rts_n), .rx_data_available_irq(irq));
	uaf_line_partner u_line (.pclk(pclk), .rxd(rxd));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; an idle cycle follows so strobes never toggle twice in a step
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			end_of_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdck(input logic [31:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(r, exp, what);
	endtask

	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq !== lvl && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk(irq, lvl, "irq");
		if (n >= 400)
			end_of_test();
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdck(`UAF_FCR_ADDR, 32'h0, "fcr reset");
		rdck(`UAF_LCR_ADDR, 32'h0, "lcr reset");
		rdck(`UAF_MCR_ADDR, 32'h0, "mcr reset");
		chk({dtr_n, rts_n, txd}, 32'h7, "reset pins");
		$display("test reset done");
		// reserved bits 5:3 always written as zero
		apb(1'b1, `UAF_FCR_ADDR, 32'h00c0);
		rdck(`UAF_FCR_ADDR, 32'h0, "fcr gated");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `UAF_FCR_ADDR, {24'h0, i[1:0], 6'h01});
			rdck(`UAF_FCR_ADDR, {24'h0, i[1:0], 6'h01}, "fcr trigger");
		end
		apb(1'b1, `UAF_FCR_ADDR, 32'h00c7);
		rdck(`UAF_FCR_ADDR, 32'h00c1, "fcr self clear");
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `UAF_LCR_ADDR, {24'h0, lv[i]});
			rdck(`UAF_LCR_ADDR, {24'h0, lv[i]}, "lcr");
		end
		apb(1'b1, `UAF_LCR_ADDR, 32'h0040);
		// pins follow the register one edge later
		@(posedge pclk);
		chk(txd, 32'h0, "break txd");
		$display("test format done");
		apb(1'b1, `UAF_MCR_ADDR, 32'h0003);
		@(posedge pclk);
		chk({dtr_n, rts_n}, 32'h0, "modem pins");
		rdck(`UAF_MCR_ADDR, 32'h0003, "mcr");
		apb(1'b1, `UAF_MCR_ADDR, 32'h0013);
		rdck(`UAF_MCR_ADDR, 32'h0010, "mcr loop");
		chk({dtr_n, rts_n, txd}, 32'h7, "loop pins");
		apb(1'b1, `UAF_MCR_ADDR, 32'h0);
		$display("test modem done");
		// a gated write must not reach the latch
		apb(1'b1, `UAF_DIVHI_ADDR, 32'h005a);
		apb(1'b1, `UAF_LCR_ADDR, 32'h0080);
		rdck(`UAF_DIVHI_ADDR, 32'h0, "divisor shut");
		rdck(`UAF_DATA_ADDR, 32'h0001, "divisor reset");
		apb(1'b1, `UAF_DATA_ADDR, 32'h005a);
		rdck(`UAF_DATA_ADDR, 32'h005a, "divisor open");
		apb(1'b1, `UAF_DATA_ADDR, 32'h0001);
		apb(1'b1, `UAF_LCR_ADDR, 32'h0003);
		// the tick counter still runs out the longer divisor
		repeat (100) @(posedge pclk);
		rdck(32'he001_0018, 32'h0, "unmapped");
		chk(err, 32'h1, "unmapped error");
		$display("test access done");
		// trigger code 01 picks four characters
		apb(1'b1, `UAF_FCR_ADDR, 32'h0041);
		for (int i = 0; i < 4; i++) begin
			chk(irq, 32'h0, "irq below level");
			u_line.send({3'b111, 8'ha0 + i[7:0], 1'b0}, 10);
		end
		wait_irq(1'b1);
		rdck(`UAF_DATA_ADDR, 32'h00a0, "rx data");
		wait_irq(1'b0);
		apb(1'b1, `UAF_FCR_ADDR, 32'h0043);
		rdck(`UAF_STAT_ADDR, 32'h0010, "rx flushed");
		u_line.send({3'b111, 8'h55, 1'b0}, 10);
		apb(1'b0, `UAF_STAT_ADDR, 32'h0);
		chk(r[0], 32'h1, "rx held");
		apb(1'b1, `UAF_FCR_ADDR, 32'h0);
		apb(1'b0, `UAF_STAT_ADDR, 32'h0);
		chk(r[0], 32'h0, "enable change flush");
		$display("test fifo done");
		apb(1'b1, `UAF_FCR_ADDR, 32'h0001);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, `UAF_LCR_ADDR, {26'h0, c[1:0], 4'hb});
			u_line.send({2'b11, ~good[c], 8'h01, 1'b0}, 11);
			apb(1'b0, `UAF_STAT_ADDR, 32'h0);
			chk(r[1], 32'h1, "bad parity");
			apb(1'b0, `UAF_DATA_ADDR, 32'h0);
			u_line.send({2'b11, good[c], 8'h01, 1'b0}, 11);
			apb(1'b0, `UAF_STAT_ADDR, 32'h0);
			chk(r[1], 32'h0, "good parity");
			apb(1'b0, `UAF_DATA_ADDR, 32'h0);
		end
		$display("test parity done");
		// five-bit frame through the transmitter and back in loopback
		apb(1'b1, `UAF_LCR_ADDR, 32'h0000);
		apb(1'b1, `UAF_MCR_ADDR, 32'h0010);
		apb(1'b1, `UAF_DATA_ADDR, 32'h00ff);
		wait_irq(1'b1);
		rdck(`UAF_DATA_ADDR, 32'h001f, "loop five bits");
		$display("test loopback done");
		end_of_test();
	end
endmodule
